// ---- common/apd_map.svh ----
// Constant map of the power-down and initialization control link.
`ifndef APD_MAP_SVH
`define APD_MAP_SVH

`define APD_CMD_SOFT_PD    16'h8000
`define APD_CMD_INIT       16'ha000
`define APD_CMD_WAKE       16'h0000
`define APD_CFG_OP         4'ha
`define APD_CFG_OP_MSB     15
`define APD_CFG_OP_LSB     12
`define APD_CFG_INTREF_BIT 3
`define APD_CFG_RST        12'h000
`define APD_HOST_CFG_DEF   12'h001
`define APD_CLK_MHZ        200
`define APD_WAKE_NS        1000000
`define APD_WAKE_CYCLES    ((`APD_WAKE_NS * `APD_CLK_MHZ) / 1000)

`endif

// ---- common/apd_pkg.sv ----
// Types shared by both ends of the power-down and initialization link.
`default_nettype none

package apd_pkg;

   typedef enum logic [1:0] {
      DS_ACTIVE,
      DS_SOFT_PD,
      DS_HW_PD,
      DS_WAKE
   } apd_dev_state_t;

   typedef enum logic [2:0] {
      HS_INIT,
      HS_CFG,
      HS_IDLE,
      HS_SOFT_PD,
      HS_HW_PD,
      HS_WAIT
   } apd_host_state_t;

endpackage : apd_pkg

`default_nettype wire

// ---- common/apd_if.sv ----
// Link between the host end and the converter's power control end.
`default_nettype none

interface apd_if;
   logic        cmd_valid;
   logic [15:0] cmd_word;
   logic        cmd_ready;
   logic        hw_powerdown_pin;
   logic        chip_sel_n;
   logic        conversion_start_pin;
   logic        frame_sync_input;
   logic        dev_ready;
   logic        result_valid;
   logic [11:0] result_data;
   logic        result_invalid;

   modport dev (
      input  cmd_valid, cmd_word, hw_powerdown_pin, chip_sel_n, conversion_start_pin, frame_sync_input,
      output cmd_ready, dev_ready, result_valid, result_data, result_invalid
   );

   modport host (
      output cmd_valid, cmd_word, hw_powerdown_pin, chip_sel_n, conversion_start_pin, frame_sync_input,
      input  cmd_ready, dev_ready, result_valid, result_data, result_invalid
   );
endinterface : apd_if

`default_nettype wire

// ---- verilog/apd_device.sv ----
// Converter end: power-down, wake-up and initialization control.
`include "apd_map.svh"
`default_nettype none

module apd_device #(
   parameter int unsigned WAKE_CYCLES = `APD_WAKE_CYCLES,
   parameter int unsigned CW          = $clog2(WAKE_CYCLES + 1)
) (
   // Clock and reset.
   input  wire logic        core_clk,
   input  wire logic        rst,
   // Link to the host.
   apd_if.dev               lnk,
   // Converter core results.
   input  wire logic        conv_done,
   input  wire logic [11:0] conv_data,
   // Power and datapath controls.
   output logic             powered_down,
   output logic             analog_on,
   output logic             ref_on,
   output logic             fifo_clear,
   output logic             sweep_restart,
   // Stored setup.
   output logic [11:0]      config_word_store,
   output logic             proc_is_dsp,
   output logic             init_done
);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchroniser for the hardware power-down pin.

   logic hw_meta_q;
   logic hw_sync_q;

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         hw_meta_q <= 1'b0;
         hw_sync_q <= 1'b0;
      end else begin
         hw_meta_q <= lnk.hw_powerdown_pin;
         hw_sync_q <= hw_meta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power state.

   apd_pkg::apd_dev_state_t state_q;
   apd_pkg::apd_dev_state_t state_d;
   logic [CW-1:0]           cnt_q;
   logic [CW-1:0]           cnt_d;
   logic                    first_q;
   logic                    first_d;
   logic                    clr_q;
   logic                    clr_d;
   logic                    swp_q;
   logic                    swp_d;
   logic                    take;
   logic                    is_pd_cmd;
   logic                    is_init_cmd;
   logic                    is_cfg_cmd;

   assign take        = lnk.cmd_valid && lnk.cmd_ready;
   assign is_pd_cmd   = (lnk.cmd_word == `APD_CMD_SOFT_PD);
   assign is_init_cmd = (lnk.cmd_word == `APD_CMD_INIT);
   assign is_cfg_cmd  = (lnk.cmd_word[`APD_CFG_OP_MSB:`APD_CFG_OP_LSB] == `APD_CFG_OP) && !is_init_cmd;

   // Commands are refused while waking so that no setup lands in a half-powered part.
   assign lnk.cmd_ready = !hw_sync_q && (state_q != apd_pkg::DS_WAKE);

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      first_d = first_q;
      clr_d   = 1'b0;
      swp_d   = 1'b0;
      if (conv_done && (state_q == apd_pkg::DS_ACTIVE)) begin
         first_d = 1'b0;
      end
      unique case (state_q)
         apd_pkg::DS_ACTIVE: begin
            if (hw_sync_q) begin
               state_d = apd_pkg::DS_HW_PD;
               clr_d   = 1'b1;
               swp_d   = 1'b1;
            end else if (take && is_pd_cmd) begin
               state_d = apd_pkg::DS_SOFT_PD;
               clr_d   = 1'b1;
               swp_d   = 1'b1;
            end else if (take && is_cfg_cmd) begin
               clr_d = 1'b1;
            end
         end
         apd_pkg::DS_SOFT_PD: begin
            if (hw_sync_q) begin
               state_d = apd_pkg::DS_HW_PD;
            end else if (take && !is_pd_cmd) begin
               state_d = apd_pkg::DS_WAKE;
               cnt_d   = CW'(WAKE_CYCLES - 1);
            end
         end
         apd_pkg::DS_HW_PD: begin
            if (!hw_sync_q) begin
               state_d = apd_pkg::DS_WAKE;
               cnt_d   = CW'(WAKE_CYCLES - 1);
            end
         end
         apd_pkg::DS_WAKE: begin
            if (hw_sync_q) begin
               state_d = apd_pkg::DS_HW_PD;
            end else if (cnt_q == '0) begin
               state_d = apd_pkg::DS_ACTIVE;
               first_d = 1'b1;
            end else begin
               cnt_d = cnt_q - CW'(1);
            end
         end
      endcase
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_q <= apd_pkg::DS_ACTIVE;
         cnt_q   <= '0;
         first_q <= 1'b1;
         clr_q   <= 1'b0;
         swp_q   <= 1'b0;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         first_q <= first_d;
         clr_q   <= clr_d;
         swp_q   <= swp_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Stored setup. Power down never touches it; only reset and the init and config commands do.

   logic [11:0] cfg_q;
   logic [11:0] cfg_d;
   logic        dsp_q;
   logic        dsp_d;
   logic        init_q;
   logic        init_d;

   always_comb begin
      cfg_d  = cfg_q;
      dsp_d  = dsp_q;
      init_d = init_q;
      if (take && (state_q == apd_pkg::DS_ACTIVE)) begin
         if (is_init_cmd) begin
            // The processor type follows the frame sync level seen with the init word.
            dsp_d  = lnk.frame_sync_input;
            init_d = 1'b1;
         end else if (is_cfg_cmd) begin
            cfg_d = lnk.cmd_word[11:0];
         end
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cfg_q  <= `APD_CFG_RST;
         dsp_q  <= 1'b0;
         init_q <= 1'b0;
      end else begin
         cfg_q  <= cfg_d;
         dsp_q  <= dsp_d;
         init_q <= init_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Result path with the first-after-wake marking.

   logic        res_vld_q;
   logic        res_vld_d;
   logic [11:0] res_dat_q;
   logic [11:0] res_dat_d;
   logic        res_inv_q;
   logic        res_inv_d;

   always_comb begin
      res_vld_d = 1'b0;
      res_dat_d = res_dat_q;
      res_inv_d = res_inv_q;
      if (conv_done && (state_q == apd_pkg::DS_ACTIVE) && !lnk.hw_powerdown_pin) begin
         res_vld_d = 1'b1;
         res_dat_d = conv_data;
         res_inv_d = first_q;
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         res_vld_q <= 1'b0;
         res_dat_q <= '0;
         res_inv_q <= 1'b0;
      end else begin
         res_vld_q <= res_vld_d;
         res_dat_q <= res_dat_d;
         res_inv_q <= res_inv_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs. The raw pin gates power directly, so no clock edge is needed to shut down.

   logic accessed;

   // Analog auto power down has no enable: it follows access alone, within the same cycle; setup bit 3 keeps the reference on.
   assign accessed = !lnk.chip_sel_n || lnk.conversion_start_pin;

   assign powered_down = lnk.hw_powerdown_pin || (state_q != apd_pkg::DS_ACTIVE);
   assign analog_on    = !powered_down && accessed;
   assign ref_on       = !powered_down && (accessed || cfg_q[`APD_CFG_INTREF_BIT]);
   assign fifo_clear   = clr_q || powered_down;
   assign sweep_restart = swp_q || powered_down;

   assign config_word_store = cfg_q;
   assign proc_is_dsp       = dsp_q;
   assign init_done         = init_q;

   assign lnk.dev_ready      = !powered_down;
   assign lnk.result_valid   = res_vld_q;
   assign lnk.result_data    = res_dat_q;
   assign lnk.result_invalid = res_inv_q;

endmodule : apd_device

`default_nettype wire

// ---- verilog/apd_host.sv ----
// Host end: initialization, power-down requests and result screening.
`include "apd_map.svh"
`default_nettype none

module apd_host #(
   parameter int unsigned WAKE_CYCLES = `APD_WAKE_CYCLES,
   parameter int unsigned CW          = $clog2(WAKE_CYCLES + 1)
) (
   // Clock and reset.
   input  wire logic        core_clk,
   input  wire logic        rst,
   // Link to the converter.
   apd_if.host              lnk,
   // User requests.
   input  wire logic        usr_pd_req,
   input  wire logic        usr_wake_req,
   input  wire logic        usr_hw_pd,
   input  wire logic        usr_cfg_req,
   input  wire logic [11:0] usr_cfg_data,
   input  wire logic        usr_access,
   input  wire logic        usr_dsp,
   // User status and results.
   output logic             usr_ready,
   output logic             usr_result_valid,
   output logic [11:0]      usr_result_data
);

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer and command sender.

   apd_pkg::apd_host_state_t state_q;
   apd_pkg::apd_host_state_t state_d;
   logic [CW-1:0]            cnt_q;
   logic [CW-1:0]            cnt_d;
   logic                     vld_q;
   logic                     vld_d;
   logic [15:0]              word_q;
   logic [15:0]              word_d;
   logic [11:0]              cfg_q;
   logic [11:0]              cfg_d;

   always_comb begin
      state_d = state_q;
      cnt_d   = cnt_q;
      vld_d   = vld_q && !lnk.cmd_ready;
      word_d  = word_q;
      cfg_d   = cfg_q;
      if (!vld_q) begin
         unique case (state_q)
            apd_pkg::HS_INIT: begin
               vld_d   = 1'b1;
               word_d  = `APD_CMD_INIT;
               state_d = apd_pkg::HS_CFG;
            end
            apd_pkg::HS_CFG: begin
               vld_d   = 1'b1;
               word_d  = {`APD_CFG_OP, cfg_q};
               state_d = apd_pkg::HS_IDLE;
            end
            apd_pkg::HS_IDLE: begin
               if (usr_hw_pd) begin
                  state_d = apd_pkg::HS_HW_PD;
               end else if (usr_pd_req) begin
                  vld_d   = 1'b1;
                  word_d  = `APD_CMD_SOFT_PD;
                  state_d = apd_pkg::HS_SOFT_PD;
               end else if (usr_cfg_req) begin
                  cfg_d   = usr_cfg_data;
                  state_d = apd_pkg::HS_CFG;
               end
            end
            apd_pkg::HS_SOFT_PD: begin
               if (usr_hw_pd) begin
                  state_d = apd_pkg::HS_HW_PD;
               end else if (usr_wake_req) begin
                  vld_d   = 1'b1;
                  word_d  = `APD_CMD_WAKE;
                  state_d = apd_pkg::HS_WAIT;
                  cnt_d   = CW'(WAKE_CYCLES);
               end
            end
            apd_pkg::HS_HW_PD: begin
               if (!usr_hw_pd) begin
                  state_d = apd_pkg::HS_WAIT;
                  cnt_d   = CW'(WAKE_CYCLES);
               end
            end
            apd_pkg::HS_WAIT: begin
               // Waits out the wake time plus sync latency before trusting the converter.
               if (usr_hw_pd) begin
                  state_d = apd_pkg::HS_HW_PD;
               end else if ((cnt_q == '0) && lnk.dev_ready) begin
                  state_d = apd_pkg::HS_IDLE;
               end else if (cnt_q != '0) begin
                  cnt_d = cnt_q - CW'(1);
               end
            end
         endcase
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_q <= apd_pkg::HS_INIT;
         cnt_q   <= '0;
         vld_q   <= 1'b0;
         word_q  <= '0;
         // A zero setup would go out as the init word, so the host starts from a nonzero one.
         cfg_q   <= `APD_HOST_CFG_DEF;
      end else begin
         state_q <= state_d;
         cnt_q   <= cnt_d;
         vld_q   <= vld_d;
         word_q  <= word_d;
         cfg_q   <= cfg_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pins and result screening.

   logic        hw_q;
   logic        cs_n_q;
   logic        cst_q;
   logic        fs_q;
   logic        rv_q;
   logic        rv_d;
   logic [11:0] rd_q;
   logic [11:0] rd_d;

   always_comb begin
      rv_d = lnk.result_valid && !lnk.result_invalid;
      rd_d = lnk.result_valid ? lnk.result_data : rd_q;
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         hw_q   <= 1'b0;
         cs_n_q <= 1'b1;
         cst_q  <= 1'b0;
         fs_q   <= 1'b0;
         rv_q   <= 1'b0;
         rd_q   <= '0;
      end else begin
         hw_q   <= usr_hw_pd;
         cs_n_q <= !usr_access;
         cst_q  <= usr_access;
         fs_q   <= usr_dsp;
         rv_q   <= rv_d;
         rd_q   <= rd_d;
      end
   end

   assign lnk.cmd_valid            = vld_q;
   assign lnk.cmd_word             = word_q;
   assign lnk.hw_powerdown_pin     = hw_q;
   assign lnk.chip_sel_n           = cs_n_q;
   assign lnk.conversion_start_pin = cst_q;
   assign lnk.frame_sync_input     = fs_q;

   assign usr_ready        = (state_q == apd_pkg::HS_IDLE) && !vld_q;
   assign usr_result_valid = rv_q;
   assign usr_result_data  = rd_q;

endmodule : apd_host

`default_nettype wire

// ---- dv/apd_properties.sv ----
// Checker of the power control link between the host end and the converter end.
`include "apd_map.svh"
`default_nettype none

module apd_properties #(
   parameter int unsigned WAKE_CYCLES = `APD_WAKE_CYCLES
) (
   // Clock and reset.
   input wire logic        core_clk,
   input wire logic        rst,
   // Host to converter.
   input wire logic        cmd_valid,
   input wire logic [15:0] cmd_word,
   input wire logic        hw_powerdown_pin,
   input wire logic        chip_sel_n,
   input wire logic        conversion_start_pin,
   input wire logic        frame_sync_input,
   // Converter to host.
   input wire logic        cmd_ready,
   input wire logic        dev_ready,
   input wire logic        result_valid,
   input wire logic [11:0] result_data,
   input wire logic        result_invalid
);
   logic [15:0] low_q;
   logic        first_q;
   logic        seen_q;

   default clocking dcb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   // The low-time count saturates so a long power down cannot wrap it.
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         low_q   <= 16'h0000;
         first_q <= 1'b1;
         seen_q  <= 1'b0;
      end else begin
         low_q   <= dev_ready ? 16'h0000 : low_q + {15'h0000, low_q != 16'hffff};
         first_q <= !dev_ready || (first_q && !result_valid);
         seen_q  <= seen_q || cmd_valid;
      end
   end

   sequence s_pd_taken;
      cmd_valid && cmd_ready && cmd_word == 16'h8000 && dev_ready;
   endsequence
   sequence s_init_taken;
      cmd_valid && cmd_ready && cmd_word == 16'ha000;
   endsequence
   sequence s_hw_held;
      hw_powerdown_pin [*3];
   endsequence

   a_soft_pd_entry: assert property (s_pd_taken |=> !dev_ready)
      else $error("soft power down not entered");
   a_first_command: assert property (cmd_valid && !seen_q |-> cmd_word == 16'ha000)
      else $error("first command is not the init word");
   a_cfg_follows: assert property (s_init_taken |-> ##[1:8] (cmd_valid && cmd_word[15:12] == 4'ha))
      else $error("no configuration after init");
   a_cmd_hold: assert property (cmd_valid && !cmd_ready |=> cmd_valid && $stable(cmd_word))
      else $error("command changed before taken");
   a_cmd_drop: assert property (cmd_valid && cmd_ready |=> !cmd_valid)
      else $error("command held after taken");
   a_hw_async: assert property (hw_powerdown_pin |-> !dev_ready)
      else $error("pin did not power down at once");
   a_hw_refuse: assert property (s_hw_held |-> !cmd_ready)
      else $error("command accepted in pin power down");
   a_hw_resume: assert property ($fell(hw_powerdown_pin) |-> !dev_ready [*8])
      else $error("ready too soon after pin release");
   a_wake_time: assert property ($rose(dev_ready) |-> low_q >= WAKE_CYCLES)
      else $error("wake delay too short");
   a_result_gate: assert property (result_valid |-> $past(dev_ready))
      else $error("result while powered down");
   a_first_invalid: assert property (result_valid |-> result_invalid == first_q)
      else $error("first result flag wrong");
   a_result_paired: assert property ($changed(result_data) |-> result_valid)
      else $error("result data changed without a result");
endmodule : apd_properties

`default_nettype wire

// ---- dv/tb.sv ----
// Testbench joining the host end and the converter end across the link.
`include "apd_map.svh"
`default_nettype none

module tb;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int unsigned WC = 8;

   logic core_clk, rst, usr_pd_req, usr_wake_req, usr_hw_pd, usr_cfg_req, usr_access, usr_dsp;
   logic [11:0] usr_cfg_data, conv_data, config_word_store, usr_result_data;
   logic conv_done, powered_down, analog_on, ref_on, fifo_clear, sweep_restart;
   logic proc_is_dsp, init_done, usr_ready, usr_result_valid;
   logic [11:0] exp_q[$];
   int miscompares = 0;
   int n_compared = 0;
   int cyc = 0;

   apd_if lnk_if ();
   apd_device #(.WAKE_CYCLES(WC)) apd_device_inst (.core_clk(core_clk), .rst(rst), .lnk(lnk_if),
      .conv_done(conv_done), .conv_data(conv_data), .powered_down(powered_down), .analog_on(analog_on),
      .ref_on(ref_on), .fifo_clear(fifo_clear), .sweep_restart(sweep_restart),
      .config_word_store(config_word_store), .proc_is_dsp(proc_is_dsp), .init_done(init_done));
   apd_host #(.WAKE_CYCLES(WC)) apd_host_inst (.core_clk(core_clk), .rst(rst), .lnk(lnk_if),
      .usr_pd_req(usr_pd_req), .usr_wake_req(usr_wake_req), .usr_hw_pd(usr_hw_pd),
      .usr_cfg_req(usr_cfg_req), .usr_cfg_data(usr_cfg_data), .usr_access(usr_access), .usr_dsp(usr_dsp),
      .usr_ready(usr_ready), .usr_result_valid(usr_result_valid), .usr_result_data(usr_result_data));
   apd_properties #(.WAKE_CYCLES(WC)) apd_properties_inst (.core_clk(core_clk), .rst(rst),
      .cmd_valid(lnk_if.cmd_valid), .cmd_word(lnk_if.cmd_word), .hw_powerdown_pin(lnk_if.hw_powerdown_pin),
      .chip_sel_n(lnk_if.chip_sel_n), .conversion_start_pin(lnk_if.conversion_start_pin),
      .frame_sync_input(lnk_if.frame_sync_input), .cmd_ready(lnk_if.cmd_ready), .dev_ready(lnk_if.dev_ready),
      .result_valid(lnk_if.result_valid), .result_data(lnk_if.result_data),
      .result_invalid(lnk_if.result_invalid));

   ////////////////////////////////////////////////////////////////////////////////
   task end_sim;
      $display("compared %0d miscompares %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : end_sim

   task chk(input string nm, input logic [11:0] e, input logic [11:0] g);
      n_compared++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s expected %h seen %h", nm, e, g);
      end
   endtask : chk

   // Bounded wait on usr_ready (which 0) or dev_ready (which 1); n returns the cycles spent.
   task wait_on(input bit which, input logic lvl, output int n);
      for (n = 1; n < 300; n++) begin
         @(negedge core_clk);
         if ((which ? lnk_if.dev_ready : usr_ready) === lvl)
            return;
      end
      chk("wait", lvl, ~lvl);
   endtask : wait_on

   // Back-to-back conversions; results before index keep are not expected to reach the user.
   task convs(input int n, input int keep);
      logic [11:0] d;
      for (int i = 0; i < n; i++) begin
         @(negedge core_clk);
         d = 12'($urandom);
         conv_done = 1'b1;
         conv_data = d;
         if (i >= keep)
            exp_q.push_back(d);
      end
      @(negedge core_clk);
      conv_done = 1'b0;
      repeat (4) @(negedge core_clk);
   endtask : convs

   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #2.5 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 5000) begin
         miscompares++;
         end_sim();
      end
   end

   always @(negedge core_clk) begin
      if (usr_result_valid === 1'b1) begin
         if (exp_q.size() == 0)
            chk("result_extra", 12'h000, 12'h001);
         else
            chk("result", exp_q.pop_front(), usr_result_data);
      end
   end

   initial begin
      logic [11:0] d;
      int n;
      {rst, usr_dsp, usr_access} = 3'b111;
      {usr_pd_req, usr_wake_req, usr_hw_pd, usr_cfg_req, conv_done} = 5'h00;
      usr_cfg_data = 12'h000;
      conv_data = 12'h000;
      void'($urandom(9));
      repeat (6) @(negedge core_clk);
      rst = 1'b0;
      wait_on(0, 1'b1, n);
      chk("proc_dsp", 12'h001, proc_is_dsp);
      chk("init_done", 12'h001, init_done);
      chk("cfg_init", `APD_HOST_CFG_DEF, config_word_store);
      for (int b = 0; b < 2; b++) begin
         d = 12'($urandom) | 12'h100;
         d[3] = b[0];
         usr_cfg_data = d;
         usr_cfg_req = 1'b1;
         @(negedge core_clk);
         usr_cfg_req = 1'b0;
         wait_on(0, 1'b1, n);
         chk("fifo_clear_cfg", 12'h001, fifo_clear);
         @(negedge core_clk);
         chk("cfg", d, config_word_store);
         usr_access = 1'b0;
         repeat (2) @(negedge core_clk);
         chk("analog_idle", 12'h000, analog_on);
         chk("ref_idle", {11'h000, b[0]}, ref_on);
         usr_access = 1'b1;
         repeat (2) @(negedge core_clk);
         chk("analog_act", 12'h001, analog_on);
         convs(3, b == 0 ? 1 : 0);
      end
      // Soft power down first, then the hardware pin; both must look the same from outside.
      for (int m = 0; m < 2; m++) begin
         if (m == 0)
            usr_pd_req = 1'b1;
         else
            usr_hw_pd = 1'b1;
         @(negedge core_clk);
         usr_pd_req = 1'b0;
         wait_on(1, 1'b0, n);
         chk("powered_down", 12'h001, powered_down);
         chk("ref_off", 12'h000, ref_on);
         chk("fifo_clear", 12'h001, fifo_clear);
         chk("sweep_restart", 12'h001, sweep_restart);
         convs(2, 2);
         chk("cfg_kept", d, config_word_store);
         if (m == 0)
            usr_wake_req = 1'b1;
         else
            usr_hw_pd = 1'b0;
         @(negedge core_clk);
         usr_wake_req = 1'b0;
         wait_on(1, 1'b1, n);
         chk("wake_wait", 12'h001, {11'h000, n >= WC});
         wait_on(0, 1'b1, n);
         chk("cfg_after", d, config_word_store);
         convs(3, 1);
      end
      repeat (4) @(negedge core_clk);
      chk("queue_left", 12'h000, 12'(exp_q.size()));
      end_sim();
   end
endmodule : tb

`default_nettype wire
